// ---- scdc_controller.sv ----
// Host-side controller for a 1M x 9 static-column DRAM: accesses, refresh and wake-up.
// Assumes a 10 MHz clock; strobe edges are one clock apart save at refresh end and wake-up into refresh, where both switch at once; covers all minimum times.
// Functional notes
// - All 512 rows are refreshed at least once every 8 ms, in any order.
// - After power-up wait 100 us and then run 8 row-strobe cycles before any access.
// - The 8-cycle wake-up is repeated whenever the 8 ms refresh interval was exceeded.
// - The column strobe is raised for at least the column precharge time before a new access.
// - In a read the write select stays high until the column or row strobe rises.
// - Hidden refresh cycles the row strobe with the column strobe held low.
// - Row-only refresh drives the row on the low nine lines with the column strobe high.
// - Column-before-row refresh lowers the column strobe at least 10 ns before the row strobe.
// - The row strobe stays low at most 100,000 ns, page accesses spaced by the cycle time.
// - Row is latched on the row strobe fall, column on the column strobe fall; write select low writes.
// - With the row strobe low, new columns in the same row give faster accesses.
`timescale 1ns/100ps
`include "scdc_defs.svh"
module scdc_controller (
  // Clock and reset
  input  wire logic                        CLOCK_IN,
  input  wire logic                        SRST_IN,
  // Request port
  input  wire logic                        REQ_VALID_IN,
  input  wire scdc_pkg::scdc_req_t         REQ_IN,
  output logic                             REQ_READY_OUT,
  output logic                             RD_VALID_OUT,
  output logic [`SCDC_DATA_BITS-1:0]       RD_DATA_OUT,
  output logic                             INIT_DONE_OUT,
  // DRAM pins
  output scdc_pkg::scdc_pins_t             DRAM_OUT,
  output logic [`SCDC_DATA_BITS-1:0]       DRAM_DQ_OUT,
  output logic                             DRAM_DQ_OE_OUT,
  input  wire logic [`SCDC_DATA_BITS-1:0]  DRAM_DQ_IN
);
  import scdc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  scdc_state_t                 state;
  scdc_state_t                 next_state;
  scdc_pins_t                  pins;
  scdc_pins_t                  next_pins;
  logic [15:0]                 timer;
  logic [15:0]                 next_timer;
  logic [15:0]                 open_cnt;
  logic [15:0]                 next_open_cnt;
  logic [3:0]                  wake_cnt;
  logic [3:0]                  next_wake_cnt;
  logic                        init_done;
  logic                        next_init_done;
  logic                        page_open;
  logic                        next_page_open;
  logic [`SCDC_ROW_BITS-1:0]   open_row;
  logic [`SCDC_ROW_BITS-1:0]   next_open_row;
  scdc_req_t                   cur;
  scdc_req_t                   next_cur;
  logic [`SCDC_DATA_BITS-1:0]  rd_data;
  logic [`SCDC_DATA_BITS-1:0]  next_rd_data;
  logic                        rd_valid;
  logic                        next_rd_valid;
  logic [`SCDC_DATA_BITS-1:0]  dq_out;
  logic [`SCDC_DATA_BITS-1:0]  next_dq_out;
  logic                        dq_oe;
  logic                        next_dq_oe;
  logic                        ref_taken;
  logic                        ref_due;
  logic                        ref_urgent;
  logic                        ref_overrun;
  logic                        take_req;
  logic                        hit;
  logic                        page_limit;

  scdc_refresh_timer u_timer (
    .clk_in      (CLOCK_IN),
    .srst_in     (SRST_IN),
    .taken_in    (ref_taken),
    .due_out     (ref_due),
    .urgent_out  (ref_urgent),
    .overrun_out (ref_overrun)
  );

  // A request is taken only when the sequencer will serve it on this very edge: a miss on an
  // open page closes the page first and leaves the request pending.
  assign hit           = page_open && (REQ_IN.row == open_row);
  assign page_limit    = page_open && (open_cnt >= 16'(`SCDC_PAGE_OPEN_MAX_CYC));
  assign take_req      = (state == ST_IDLE) && init_done && REQ_VALID_IN && !ref_overrun
                         && !page_limit && (hit || !page_open)
                         && !(ref_urgent || (ref_due && !hit));
  assign REQ_READY_OUT = take_req;
  assign ref_taken     = (state == ST_CBR_RAS);
  assign INIT_DONE_OUT = init_done;
  assign RD_VALID_OUT  = rd_valid;
  assign RD_DATA_OUT   = rd_data;
  assign DRAM_OUT      = pins;
  assign DRAM_DQ_OUT   = dq_out;
  assign DRAM_DQ_OE_OUT = dq_oe;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_pins      = pins;
    next_timer     = timer;
    next_wake_cnt  = wake_cnt;
    next_init_done = init_done;
    next_page_open = page_open;
    next_open_row  = open_row;
    next_cur       = cur;
    next_rd_data   = rd_data;
    next_rd_valid  = 1'b0;
    next_dq_out    = dq_out;
    next_dq_oe     = dq_oe;
    next_open_cnt  = page_open ? open_cnt + 16'h0001 : 16'h0000;
    case (state)
      ST_POWERUP: begin
        next_timer = timer + 16'h0001;
        if (timer == 16'((`SCDC_POWERUP_CYC) - 1)) begin
          next_state    = ST_WAKE_LO;
          next_wake_cnt = 4'h0;
        end
      end
      ST_WAKE_LO: begin
        next_pins.row_strobe_n = 1'b0;
        next_state             = ST_WAKE_HI;
      end
      ST_WAKE_HI: begin
        next_pins.row_strobe_n = 1'b1;
        next_wake_cnt          = wake_cnt + 4'h1;
        if (wake_cnt == 4'(`SCDC_WAKE_CYCLES - 1)) begin
          next_init_done = 1'b1;
          if (ref_due) begin
            // An owed refresh is served first; it also clears the overrun behind a re-wake.
            next_pins.col_strobe_n = 1'b0;
            next_state             = ST_CBR_CAS;
          end else begin
            next_state = ST_IDLE;
          end
        end else begin
          next_state = ST_WAKE_LO;
        end
      end
      ST_IDLE: begin
        if (ref_overrun && init_done) begin
          next_init_done = 1'b0;
          next_state     = ST_PRECHARGE;
          next_timer     = 16'h0000;
        end else if (take_req) begin
          next_cur = REQ_IN;
          if (hit) begin
            next_pins.addr        = REQ_IN.col;
            next_pins.write_sel_n = !REQ_IN.write;
            next_dq_out           = REQ_IN.wdata;
            next_dq_oe            = REQ_IN.write;
            next_state            = ST_RD_COL;
          end else begin
            next_pins.addr = REQ_IN.row;
            next_state     = ST_RD_ROW;
          end
        end else if (page_open && (page_limit || ref_due || REQ_VALID_IN)) begin
          next_state = ST_CLOSE;
        end else if (ref_due) begin
          // Only column-before-row refresh is issued; hidden and row-only cycles are never used.
          next_pins.col_strobe_n = 1'b0;
          next_state             = ST_CBR_CAS;
        end
      end
      ST_RD_ROW: begin
        next_pins.row_strobe_n = 1'b0;
        next_page_open         = 1'b1;
        next_open_row          = cur.row;
        if (!pins.row_strobe_n) begin
          // The column goes out one clock after the row strobe fell, so the row is held.
          next_pins.addr        = cur.col;
          next_pins.write_sel_n = !cur.write;
          next_dq_out           = cur.wdata;
          next_dq_oe            = cur.write;
          next_state            = ST_RD_COL;
        end
      end
      ST_RD_COL: begin
        next_pins.col_strobe_n = 1'b0;
        next_state             = ST_RD_DATA;
      end
      ST_RD_DATA: begin
        if (!cur.write) begin
          next_rd_data  = DRAM_DQ_IN;
          next_rd_valid = 1'b1;
        end
        next_pins.col_strobe_n = 1'b1;
        next_pins.write_sel_n  = 1'b1;
        next_dq_oe             = 1'b0;
        next_state             = ST_IDLE;
      end
      ST_CLOSE: begin
        next_pins.row_strobe_n = 1'b1;
        next_page_open         = 1'b0;
        next_state             = ST_IDLE;
      end
      ST_CBR_CAS: begin
        next_pins.row_strobe_n = 1'b0;
        next_state             = ST_CBR_RAS;
      end
      ST_CBR_RAS: begin
        next_pins.row_strobe_n = 1'b1;
        next_pins.col_strobe_n = 1'b1;
        next_state             = ST_CBR_END;
      end
      ST_CBR_END: begin
        next_state = ST_IDLE;
      end
      ST_PRECHARGE: begin
        next_pins.row_strobe_n = 1'b1;
        next_pins.col_strobe_n = 1'b1;
        next_page_open         = 1'b0;
        next_wake_cnt          = 4'h0;
        next_state             = ST_WAKE_LO;
      end
      default: begin
        next_state = ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      state     <= ST_POWERUP;
      pins      <= '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, write_sel_n: 1'b1,
                     addr: 10'h000};
      timer     <= 16'h0000;
      open_cnt  <= 16'h0000;
      wake_cnt  <= 4'h0;
      init_done <= 1'b0;
      page_open <= 1'b0;
      open_row  <= 10'h000;
      cur       <= '0;
      rd_data   <= 9'h000;
      rd_valid  <= 1'b0;
      dq_out    <= 9'h000;
      dq_oe     <= 1'b0;
    end else begin
      state     <= next_state;
      pins      <= next_pins;
      timer     <= next_timer;
      open_cnt  <= next_open_cnt;
      wake_cnt  <= next_wake_cnt;
      init_done <= next_init_done;
      page_open <= next_page_open;
      open_row  <= next_open_row;
      cur       <= next_cur;
      rd_data   <= next_rd_data;
      rd_valid  <= next_rd_valid;
      dq_out    <= next_dq_out;
      dq_oe     <= next_dq_oe;
    end
  end
endmodule

// ---- scdc_defs.svh ----
// Timing constants for the static-column DRAM controller.
// Assumes a 10 MHz controller clock (100 ns period).
`ifndef SCDC_DEFS_SVH
`define SCDC_DEFS_SVH
`define SCDC_CLK_NS            100
`define SCDC_POWERUP_US        100
`define SCDC_POWERUP_CYC       ((`SCDC_POWERUP_US * 1000 + `SCDC_CLK_NS - 1) / `SCDC_CLK_NS)
`define SCDC_WAKE_CYCLES       8
`define SCDC_REF_ROWS          512
`define SCDC_REF_PERIOD_MS     8
`define SCDC_REF_INTERVAL_CYC  ((`SCDC_REF_PERIOD_MS * 1000000) / `SCDC_REF_ROWS / `SCDC_CLK_NS)
`define SCDC_REF_URGENT_CYC    8
`define SCDC_PAGE_OPEN_MAX_NS  100000
`define SCDC_PAGE_OPEN_MAX_CYC (`SCDC_PAGE_OPEN_MAX_NS / `SCDC_CLK_NS - 4)
`define SCDC_ROW_BITS          10
`define SCDC_COL_BITS          10
`define SCDC_DATA_BITS         9
`endif

// ---- scdc_pkg.sv ----
// Types for the static-column DRAM controller.
// Assumes scdc_defs.svh is on the include path.
`include "scdc_defs.svh"
package scdc_pkg;
  typedef struct packed {
    logic                         write;
    logic [`SCDC_ROW_BITS-1:0]    row;
    logic [`SCDC_COL_BITS-1:0]    col;
    logic [`SCDC_DATA_BITS-1:0]   wdata;
  } scdc_req_t;
  typedef struct packed {
    logic                         row_strobe_n;
    logic                         col_strobe_n;
    logic                         write_sel_n;
    logic [`SCDC_ROW_BITS-1:0]    addr;
  } scdc_pins_t;
  typedef enum {
    ST_POWERUP, ST_WAKE_LO, ST_WAKE_HI, ST_IDLE,
    ST_RD_ROW, ST_RD_COL, ST_RD_DATA, ST_CLOSE,
    ST_CBR_CAS, ST_CBR_RAS, ST_CBR_END, ST_PRECHARGE
  } scdc_state_t;
endpackage

// ---- scdc_refresh_timer.sv ----
// Refresh interval timer: raises due when a refresh is owed and urgent near the deadline.
// Assumes taken_in pulses once each time a refresh cycle is issued.
`timescale 1ns/100ps
`include "scdc_defs.svh"
module scdc_refresh_timer (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic taken_in,
  output logic      due_out,
  output logic      urgent_out,
  output logic      overrun_out
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        owed;
  logic        next_owed;
  logic        overrun;
  logic        next_overrun;

  always_comb begin
    next_count   = count;
    next_owed    = owed;
    next_overrun = overrun;
    if (count == 16'((`SCDC_REF_INTERVAL_CYC) - 1)) begin
      next_count = 16'h0000;
      if (owed && !taken_in) begin
        next_overrun = 1'b1;
      end
      next_owed = 1'b1;
    end else begin
      next_count = count + 16'h0001;
      if (taken_in) begin
        next_owed    = 1'b0;
        next_overrun = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count   <= 16'h0000;
      owed    <= 1'b0;
      overrun <= 1'b0;
    end else begin
      count   <= next_count;
      owed    <= next_owed;
      overrun <= next_overrun;
    end
  end

  assign due_out     = owed;
  assign urgent_out  = owed && (count >= 16'((`SCDC_REF_INTERVAL_CYC) - `SCDC_REF_URGENT_CYC));
  assign overrun_out = overrun;
endmodule

// ---- scdc_dram_model.sv ----
// Behavioural model of the static-column DRAM on the controller's pins.
// Assumes the controller's registered strobes; no timing checks.
`timescale 1ns/100ps
module scdc_dram_model (
  // Controller side
  input  wire scdc_pkg::scdc_pins_t pins_in,
  input  wire logic [8:0]           dq_in,
  input  wire logic                 dq_oe_in,
  // Device side
  output logic [8:0]                dq_out,
  output logic [8:0]                ref_row_out,
  output int                        ref_count_out
);
  import scdc_pkg::*;
  logic [8:0] mem [int];
  logic [9:0] row = 10'h000;
  logic [8:0] last_rd = 9'h000;
  initial begin
    ref_row_out = 9'h000;
    ref_count_out = 0;
  end
  always @(negedge pins_in.row_strobe_n) begin
    if (!pins_in.col_strobe_n) begin
      // Refresh from the own counter; the output data is left as it was.
      ref_row_out = ref_row_out + 9'h001;
      ref_count_out++;
    end else begin
      row = pins_in.addr;
    end
  end
  always @(negedge pins_in.col_strobe_n) begin
    if (!pins_in.row_strobe_n && !pins_in.write_sel_n) begin
      // An undriven bus writes the inverse of the last value seen.
      mem[{row, pins_in.addr}] = dq_oe_in ? dq_in : ~dq_in;
    end else if (!pins_in.row_strobe_n) begin
      last_rd = mem.exists({row, pins_in.addr}) ? mem[{row, pins_in.addr}] : 9'h155;
    end
  end
  // High impedance is modelled by the inverse of the last value.
  assign dq_out = pins_in.col_strobe_n ? ~last_rd : last_rd;
endmodule

// ---- scdc_ctrl_props.sv ----
// Concurrent checks on the controller's DRAM pins and handshake.
// Assumes a bind to scdc_controller; one clock domain.
`timescale 1ns/100ps
module scdc_ctrl_props (
  input  wire logic                 CLOCK_IN,
  input  wire logic                 SRST_IN,
  input  wire logic                 REQ_READY_OUT,
  input  wire logic                 INIT_DONE_OUT,
  input  wire scdc_pkg::scdc_pins_t DRAM_OUT,
  input  wire logic                 DRAM_DQ_OE_OUT
);
  import scdc_pkg::*;
  logic        ras;
  logic        cas;
  logic        wen;
  logic [10:0] since_rst;
  logic [10:0] ras_low;
  logic [10:0] ref_gap;
  logic [3:0]  wake;
  assign ras = DRAM_OUT.row_strobe_n;
  assign cas = DRAM_OUT.col_strobe_n;
  assign wen = DRAM_OUT.write_sel_n;
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      since_rst <= 11'h000;
      ras_low <= 11'h000;
      ref_gap <= 11'h000;
      wake <= 4'h0;
    end else begin
      since_rst <= (since_rst == 11'h7FF) ? since_rst : since_rst + 11'h001;
      ras_low <= ras ? 11'h000 : ras_low + 11'h001;
      ref_gap <= (!INIT_DONE_OUT || ($fell(ras) && !cas)) ? 11'h000 : ref_gap + 11'h001;
      if ($fell(INIT_DONE_OUT)) begin
        wake <= 4'h0;
      end else if ($fell(ras) && wake != 4'hF) begin
        wake <= wake + 4'h1;
      end
    end
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  AST_POWERUP_QUIET: assert property (since_rst < 11'h3E3 |-> ras && cas)
    else $error("strobe active during power-up wait");
  AST_WAKE_COUNT: assert property ($rose(INIT_DONE_OUT) |-> wake >= 4'h8)
    else $error("init done before eight row strobe cycles");
  AST_NO_EARLY_ACCESS: assert property (!INIT_DONE_OUT |-> !REQ_READY_OUT)
    else $error("request accepted before wake-up");
  AST_PAGE_OPEN_MAX: assert property (ras_low < 11'h3E8)
    else $error("row strobe low too long");
  AST_REFRESH_GAP: assert property (ref_gap < 11'h138)
    else $error("refresh spacing exceeded");
  AST_CBR_SETUP: assert property ($fell(ras) && !cas |-> $past(cas) == 1'b0)
    else $error("column strobe not ahead of row strobe");
  AST_CBR_END: assert property ($fell(ras) && !cas |=> ras && cas)
    else $error("refresh cycle not closed");
  AST_CAS_PRECHARGE: assert property ($rose(cas) |=> cas)
    else $error("column strobe precharge too short");
  AST_READ_HOLD: assert property (!cas && !ras && wen |=> wen || cas || ras)
    else $error("write select dropped during read");
  AST_DQ_WRITE_ONLY: assert property (DRAM_DQ_OE_OUT |-> !wen)
    else $error("data driven outside a write");
endmodule
bind scdc_controller scdc_ctrl_props u_scdc_ctrl_props (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN),
  .REQ_READY_OUT(REQ_READY_OUT), .INIT_DONE_OUT(INIT_DONE_OUT), .DRAM_OUT(DRAM_OUT),
  .DRAM_DQ_OE_OUT(DRAM_DQ_OE_OUT));

// ---- static_column_dram_refresh_cycles_test.sv ----
// Self-checking bench for scdc_controller with the DRAM model on its pins.
// Assumes scdc_pkg, the model and the checker are compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("unexpected %s: expected %0h, seen %0h", nm, ex, got); end end
module static_column_dram_refresh_cycles_test;
  import scdc_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       req_valid = 1'b0;
  scdc_req_t  req = '0;
  logic       ready, rd_valid, init_done, dq_oe;
  logic [8:0] rd_data, dq_o, dq_i, ref_row, rd;
  scdc_pins_t pins;
  int         ref_count;
  int         miscompares = 0;
  int         total_checks = 0;
  logic [9:0] rows [4] = '{10'h000, 10'h000, 10'h3FF, 10'h155};
  logic [9:0] cols [4] = '{10'h000, 10'h3FF, 10'h001, 10'h2AA};
  logic [8:0] data [4] = '{9'h1FF, 9'h0A5, 9'h000, 9'h15A};
  scdc_controller u_scdc_controller (.CLOCK_IN(clk), .SRST_IN(srst), .REQ_VALID_IN(req_valid),
    .REQ_IN(req), .REQ_READY_OUT(ready), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
    .INIT_DONE_OUT(init_done), .DRAM_OUT(pins), .DRAM_DQ_OUT(dq_o), .DRAM_DQ_OE_OUT(dq_oe),
    .DRAM_DQ_IN(dq_i));
  scdc_dram_model u_scdc_dram_model (.pins_in(pins), .dq_in(dq_o), .dq_oe_in(dq_oe),
    .dq_out(dq_i), .ref_row_out(ref_row), .ref_count_out(ref_count));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // The request is held until the edge that takes it.
  task automatic access(input logic wr, input logic [9:0] r, input logic [9:0] c,
                        input logic [8:0] wd);
    int   n;
    logic taken;
    req = '{write: wr, row: r, col: c, wdata: wd};
    req_valid = 1'b1;
    taken = 1'b0;
    for (n = 0; n < 2000 && !taken; n++) begin
      @(posedge clk);
      taken = (ready === 1'b1);
      #1;
    end
    if (!taken) begin
      miscompares++;
      stop_test();
    end
    req_valid = 1'b0;
    tick();
    for (n = 0; !wr && n < 20 && rd_valid !== 1'b1; n++) tick();
    if (n == 20) begin
      miscompares++;
      stop_test();
    end
    rd = rd_data;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_init();
    int n, bad, falls;
    logic prev;
    bad = 0;
    falls = 0;
    prev = 1'b1;
    for (n = 0; n < 1100 && init_done !== 1'b1; n++) begin
      tick();
      if (n < 990 && pins.row_strobe_n !== 1'b1) bad++;
      if (init_done !== 1'b1 && ready !== 1'b0) bad++;
      if (prev === 1'b1 && pins.row_strobe_n === 1'b0) falls++;
      prev = pins.row_strobe_n;
    end
    `CHK("power-up quiet", 0, bad)
    `CHK("wake-up strobe cycles", 8, falls)
    $display("test_init done");
  endtask
  task automatic test_access();
    int i;
    for (i = 0; i < 4; i++) access(1'b1, rows[i], cols[i], data[i]);
    for (i = 3; i >= 0; i--) begin
      access(1'b0, rows[i], cols[i], 9'h000);
      `CHK("read data", data[i], rd)
    end
    $display("test_access done");
  endtask
  task automatic test_refresh();
    int c0;
    logic [8:0] r0;
    c0 = ref_count;
    r0 = ref_row;
    repeat (400) tick();
    `CHK("refreshes issued", 1'b1, (ref_count - c0) >= 2)
    `CHK("internal row advance", 9'(ref_count - c0), 9'(ref_row - r0))
    `CHK("still initialised", 1'b1, init_done)
    access(1'b0, rows[2], cols[2], 9'h000);
    `CHK("read after refresh", data[2], rd)
    $display("test_refresh done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    test_init();
    test_access();
    test_refresh();
    stop_test();
  end
endmodule
